// [core/timer_pkg.sv]
package timer_pkg;

  localparam int CNT_W = 8;

  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL    = 8'hff;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // Clock source select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler terminal counts (divide ratio minus one)
  localparam logic [9:0] PRE_TC_8    = 10'h007;
  localparam logic [9:0] PRE_TC_64   = 10'h03f;
  localparam logic [9:0] PRE_TC_256  = 10'h0ff;
  localparam logic [9:0] PRE_TC_1024 = 10'h3ff;

  // Waveform mode codes {bit2, bit1, bit0}
  localparam logic [2:0] WGM_NORMAL     = 3'h0;
  localparam logic [2:0] WGM_PC_MAX     = 3'h1;
  localparam logic [2:0] WGM_CTC        = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX   = 3'h3;
  localparam logic [2:0] WGM_RSVD_4     = 3'h4;
  localparam logic [2:0] WGM_PC_OCRA    = 3'h5;
  localparam logic [2:0] WGM_RSVD_6     = 3'h6;
  localparam logic [2:0] WGM_FAST_OCRA  = 3'h7;

  // Flag and mask bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMA = 1;
  localparam int FLAG_CMB = 2;

  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET  = 3'h0;

  typedef enum logic [1:0] {
    CNT_HOLD,
    CNT_CLEAR,
    CNT_UP,
    CNT_DOWN
  } count_op_t;

endpackage : timer_pkg

// [core/tick_if.sv]
`timescale 1ns/1ps
// Tick source to counter unit
interface tick_if;
  logic timer_tick;
  logic running;

  modport source (output timer_tick, output running);
  modport sink   (input timer_tick, input running);
endinterface : tick_if

// [core/clock_select.sv]
`timescale 1ns/1ps
module clock_select (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  clock_source_select,
  input  wire logic        external_count_pin,
  tick_if.source           tick
);
  import timer_pkg::*;

  logic [9:0] pre_q;
  logic       ext_q;
  logic       ext_rise;
  logic       ext_fall;
  logic       pre_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Free running prescaler, held cleared while stopped
  always_ff @(posedge sys_clk) begin
    if (!reset_n || clock_source_select == CS_STOP) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // Previous pin level for edge detection
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= external_count_pin;
    end
  end

  assign ext_rise = external_count_pin & ~ext_q;
  assign ext_fall = ~external_count_pin & ext_q;

  ////////////////////////////////////////////////////////////////////////////
  // Source and edge choice
  always_comb begin
    pre_hit = 1'b0;
    unique case (clock_source_select)
      CS_STOP:     pre_hit = 1'b0;
      CS_DIV1:     pre_hit = 1'b1;
      CS_DIV8:     pre_hit = (pre_q[2:0] == PRE_TC_8[2:0]);
      CS_DIV64:    pre_hit = (pre_q[5:0] == PRE_TC_64[5:0]);
      CS_DIV256:   pre_hit = (pre_q[7:0] == PRE_TC_256[7:0]);
      CS_DIV1024:  pre_hit = (pre_q == PRE_TC_1024);
      CS_EXT_FALL: pre_hit = ext_fall;
      CS_EXT_RISE: pre_hit = ext_rise;
    endcase
  end

  assign tick.timer_tick = pre_hit;
  assign tick.running    = (clock_source_select != CS_STOP);

endmodule : clock_select

// [core/eight_bit_timer_counter_core.sv]
`timescale 1ns/1ps
// Behaviour
// - Counter and both compares are 8 bits
// - Overflow, compare A, B share flag register
// - Each request gated by its mask bit
// - Tick from prescaler or external count pin
// - Clock select picks source and edge
// - Select zero stops the counter
// - Compares checked against counter every cycle
// - Match sets channel compare flag
// - Bottom indication at counter 0x00
// - Max indication at counter 0xFF
// - Top is 0xFF or compare A
// - Tick clears, increments or decrements counter
// - Counter readable and writable anytime
// - Processor write beats count operations
// - Mode from two bits A, one B
// - Overflow flag point depends on mode
// - Top and bottom indications produced
// - Direction control selects up or down
// - Match sets flag on next tick
// - Flags clear on service or one-write
// - Counter write blocks matches next tick
// - Normal mode wraps, overflow at zero
module eight_bit_timer_counter_core (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic                        external_count_pin,
  input  wire logic [2:0]                  clock_source_select,
  input  wire logic                        waveform_mode_bit0,
  input  wire logic                        waveform_mode_bit1,
  input  wire logic                        waveform_mode_bit2,
  input  wire logic                        counter_wr,
  input  wire logic [timer_pkg::CNT_W-1:0] counter_wdata,
  input  wire logic                        compare_a_wr,
  input  wire logic [timer_pkg::CNT_W-1:0] compare_a_wdata,
  input  wire logic                        compare_b_wr,
  input  wire logic [timer_pkg::CNT_W-1:0] compare_b_wdata,
  input  wire logic                        mask_wr,
  input  wire logic [2:0]                  mask_wdata,
  input  wire logic                        flag_wr,
  input  wire logic [2:0]                  flag_wdata,
  input  wire logic [2:0]                  irq_ack,
  output logic      [timer_pkg::CNT_W-1:0] counter_value,
  output logic      [timer_pkg::CNT_W-1:0] compare_value_a,
  output logic      [timer_pkg::CNT_W-1:0] compare_value_b,
  output logic      [2:0]                  timer_flag_reg,
  output logic      [2:0]                  timer_mask_reg,
  output logic      [2:0]                  irq_req,
  output logic                             timer_tick,
  output logic                             at_top,
  output logic                             at_bottom,
  output logic                             at_max,
  output logic                             count_down
);
  import timer_pkg::*;

  tick_if tick_bus ();

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] ocra_q;
  logic [CNT_W-1:0] ocrb_q;
  logic [CNT_W-1:0] ocra_buf_q;
  logic [CNT_W-1:0] ocrb_buf_q;
  logic [CNT_W-1:0] top_val;
  logic [2:0]       flags_q;
  logic [2:0]       flags_set;
  logic [2:0]       flags_clr;
  logic [2:0]       mask_q;
  logic [2:0]       wgm;
  logic             dir_down_q;
  logic             dir_down_d;
  logic             block_q;
  logic             tick;
  logic             match_a;
  logic             match_b;
  logic             pend_a_q;
  logic             pend_b_q;
  logic             is_pwm;
  logic             is_pc;
  logic             top_is_ocra;
  logic             ovf_evt;
  count_op_t        op;

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation
  clock_select u_clock_select (
    .sys_clk             (sys_clk),
    .reset_n             (reset_n),
    .clock_source_select (clock_source_select),
    .external_count_pin  (external_count_pin),
    .tick                (tick_bus.source)
  );

  assign tick = tick_bus.timer_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign wgm         = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};
  assign is_pc       = (wgm == WGM_PC_MAX) || (wgm == WGM_PC_OCRA);
  assign is_pwm      = is_pc || (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_OCRA);
  assign top_is_ocra = (wgm == WGM_CTC) || (wgm == WGM_PC_OCRA) || (wgm == WGM_FAST_OCRA);
  assign top_val     = top_is_ocra ? ocra_q : MAX_VAL;

  // Indications from the counter value
  assign at_bottom = (cnt_q == BOTTOM_VAL);
  assign at_max    = (cnt_q == MAX_VAL);
  assign at_top    = (cnt_q == top_val);

  // Continuous comparators
  assign match_a = (cnt_q == ocra_q);
  assign match_b = (cnt_q == ocrb_q);

  ////////////////////////////////////////////////////////////////////////////
  // Count operation and direction
  always_comb begin
    op         = CNT_HOLD;
    dir_down_d = dir_down_q;
    if (tick) begin
      if (is_pc) begin
        if (at_top) begin
          dir_down_d = 1'b1;
        end else if (at_bottom) begin
          dir_down_d = 1'b0;
        end
        op = dir_down_d ? CNT_DOWN : CNT_UP;
      end else begin
        dir_down_d = 1'b0;
        if (wgm != WGM_NORMAL && at_top) begin
          op = CNT_CLEAR;
        end else begin
          op = CNT_UP;
        end
      end
    end
  end

  always_comb begin
    unique case (op)
      CNT_HOLD:  cnt_d = cnt_q;
      CNT_CLEAR: cnt_d = BOTTOM_VAL;
      CNT_UP:    cnt_d = cnt_q + 8'h01;
      CNT_DOWN:  cnt_d = cnt_q - 8'h01;
    endcase
  end

  // Counter register, processor write first
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_q <= ZERO_BYTE;
    end else if (counter_wr) begin
      cnt_q <= counter_wdata;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dir_down_q <= 1'b0;
    end else if (tick && !counter_wr) begin
      dir_down_q <= dir_down_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare registers, buffered in PWM modes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ocra_buf_q <= ZERO_BYTE;
      ocrb_buf_q <= ZERO_BYTE;
    end else begin
      if (compare_a_wr) begin
        ocra_buf_q <= compare_a_wdata;
      end
      if (compare_b_wr) begin
        ocrb_buf_q <= compare_b_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ocra_q <= ZERO_BYTE;
      ocrb_q <= ZERO_BYTE;
    end else if (!is_pwm) begin
      if (compare_a_wr) begin
        ocra_q <= compare_a_wdata;
      end
      if (compare_b_wr) begin
        ocrb_q <= compare_b_wdata;
      end
    end else if (tick && ((is_pc && at_top) || (!is_pc && at_bottom))) begin
      ocra_q <= ocra_buf_q;
      ocrb_q <= ocrb_buf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match blocking after a counter write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else if (counter_wr) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // Match seen during one tick period is flagged on the next tick
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
    end else if (tick) begin
      pend_a_q <= match_a && !block_q && !counter_wr;
      pend_b_q <= match_b && !block_q && !counter_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow event point per mode
  always_comb begin
    if (is_pc) begin
      ovf_evt = tick && at_bottom && dir_down_q;
    end else if (wgm == WGM_NORMAL || wgm == WGM_CTC) begin
      ovf_evt = tick && at_max;
    end else begin
      ovf_evt = tick && at_top;
    end
  end

  always_comb begin
    flags_set           = 3'h0;
    flags_set[FLAG_OVF] = ovf_evt && !counter_wr;
    flags_set[FLAG_CMA] = tick && pend_a_q;
    flags_set[FLAG_CMB] = tick && pend_b_q;
    flags_clr           = irq_ack | (flag_wr ? flag_wdata : 3'h0);
  end

  // Shared flag register, a set wins over a clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flags_set;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mask_q <= MASK_RESET;
    end else if (mask_wr) begin
      mask_q <= mask_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign irq_req         = flags_q & mask_q;
  assign counter_value   = cnt_q;
  assign compare_value_a = is_pwm ? ocra_buf_q : ocra_q;
  assign compare_value_b = is_pwm ? ocrb_buf_q : ocrb_q;
  assign timer_flag_reg  = flags_q;
  assign timer_mask_reg  = mask_q;
  assign timer_tick      = tick;
  assign count_down      = dir_down_q;

endmodule : eight_bit_timer_counter_core

// [dv/timer_chk.sv]
`timescale 1ns/1ps
module timer_chk (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [2:0] clock_source_select,
  input wire logic       waveform_mode_bit0,
  input wire logic       waveform_mode_bit1,
  input wire logic       waveform_mode_bit2,
  input wire logic       counter_wr,
  input wire logic [7:0] counter_wdata,
  input wire logic       flag_wr,
  input wire logic [2:0] flag_wdata,
  input wire logic [2:0] irq_ack,
  input wire logic [7:0] counter_value,
  input wire logic [2:0] timer_flag_reg,
  input wire logic [2:0] timer_mask_reg,
  input wire logic [2:0] irq_req,
  input wire logic       timer_tick,
  input wire logic       at_bottom,
  input wire logic       at_max
);
  import timer_pkg::*;
  wire logic [2:0] mode = {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Normal mode tick not overridden by a counter write
  sequence s_norm_tick;
    mode == WGM_NORMAL && timer_tick && !counter_wr;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  irq_gate_a: assert property (irq_req == (timer_flag_reg & timer_mask_reg))
    else $error("request differs from flag and mask");
  stop_hold_a: assert property (clock_source_select == CS_STOP && $stable(clock_source_select) && !counter_wr
    |=> $stable(counter_value)) else $error("stopped counter moved");
  wr_prio_a: assert property (counter_wr |=> counter_value == $past(counter_wdata))
    else $error("counter write lost");
  norm_inc_a: assert property (s_norm_tick |=> counter_value == 8'($past(counter_value) + 8'h01))
    else $error("normal mode did not increment");
  ovf_wrap_a: assert property (s_norm_tick ##0 counter_value == MAX_VAL
    |=> timer_flag_reg[FLAG_OVF] && counter_value == BOTTOM_VAL) else $error("wrap without overflow");
  bottom_ind_a: assert property (at_bottom == (counter_value == BOTTOM_VAL))
    else $error("bottom indication wrong");
  max_ind_a: assert property (at_max == (counter_value == MAX_VAL))
    else $error("max indication wrong");
  ack_clear_a: assert property (irq_ack[FLAG_OVF] && !timer_tick |=> !timer_flag_reg[FLAG_OVF])
    else $error("overflow flag kept after service");
  one_clear_a: assert property (flag_wr && flag_wdata[FLAG_CMA] && !timer_tick |=> !timer_flag_reg[FLAG_CMA])
    else $error("compare flag kept after write of one");
endmodule : timer_chk
bind eight_bit_timer_counter_core timer_chk chk_u (.sys_clk, .reset_n, .clock_source_select, .waveform_mode_bit0,
  .waveform_mode_bit1, .waveform_mode_bit2, .counter_wr, .counter_wdata, .flag_wr, .flag_wdata, .irq_ack,
  .counter_value, .timer_flag_reg, .timer_mask_reg, .irq_req, .timer_tick, .at_bottom, .at_max);

// [dv/count_pin_source.sv]
`timescale 1ns/1ps
// Board side source of edges on the external count pin
module count_pin_source (
  input wire logic sys_clk,
  output logic     external_count_pin
);
  initial external_count_pin = 1'b0;
  // Each pulse stays high and low for several clocks
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 external_count_pin = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 external_count_pin = 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask : pulses
endmodule : count_pin_source

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  logic       sys_clk, reset_n, external_count_pin, counter_wr, compare_a_wr, compare_b_wr, mask_wr, flag_wr;
  logic       waveform_mode_bit0, waveform_mode_bit1, waveform_mode_bit2, timer_tick, at_top, at_bottom;
  logic       at_max, count_down;
  logic [7:0] counter_wdata, compare_a_wdata, compare_b_wdata, counter_value, compare_value_a, compare_value_b;
  logic [2:0] clock_source_select, mask_wdata, flag_wdata, irq_ack, timer_flag_reg, timer_mask_reg, irq_req;
  int         error_cnt = 0;
  int         checked = 0;
  int         cycles = 0;

  eight_bit_timer_counter_core dut_u (.sys_clk, .reset_n, .external_count_pin, .clock_source_select,
    .waveform_mode_bit0, .waveform_mode_bit1, .waveform_mode_bit2, .counter_wr, .counter_wdata, .compare_a_wr,
    .compare_a_wdata, .compare_b_wr, .compare_b_wdata, .mask_wr, .mask_wdata, .flag_wr, .flag_wdata, .irq_ack,
    .counter_value, .compare_value_a, .compare_value_b, .timer_flag_reg, .timer_mask_reg, .irq_req, .timer_tick,
    .at_top, .at_bottom, .at_max, .count_down);
  count_pin_source pin_u (.sys_clk, .external_count_pin);

  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  // One-cycle write pulse: 0 counter, 1 compare A, 2 compare B, 3 mask, 4 flag clear, 5 service
  task automatic put(input int k, input logic [7:0] d);
    step(1);
    case (k)
      0: {counter_wr, counter_wdata} = {1'b1, d};
      1: {compare_a_wr, compare_a_wdata} = {1'b1, d};
      2: {compare_b_wr, compare_b_wdata} = {1'b1, d};
      3: {mask_wr, mask_wdata} = {1'b1, d[2:0]};
      4: {flag_wr, flag_wdata} = {1'b1, d[2:0]};
      default: irq_ack = d[2:0];
    endcase
    step(1);
    {counter_wr, compare_a_wr, compare_b_wr, mask_wr, flag_wr, irq_ack} = '0;
  endtask : put
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("Mismatches %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, counter_wr, compare_a_wr, compare_b_wr, mask_wr, flag_wr, irq_ack, clock_source_select} = '0;
    {counter_wdata, compare_a_wdata, compare_b_wdata, mask_wdata, flag_wdata} = '0;
    {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0} = WGM_NORMAL;
    step(16);
    reset_n = 1'b1;
    chk(counter_value, 8'h00);
    chk(8'(timer_flag_reg), 8'h00);
    chk(8'(timer_mask_reg), 8'h00);
    chk(8'(at_bottom), 8'h01);
    // Stopped counter takes writes and holds
    put(0, 8'h10);
    step(5);
    chk(counter_value, 8'h10);
    // Write beats a tick, then the wrap sets overflow
    clock_source_select = CS_DIV1;
    put(0, 8'hfc);
    chk(counter_value, 8'hfc);
    while (counter_value !== 8'h00) step(1);
    chk(8'(timer_flag_reg), 8'h01);
    clock_source_select = CS_STOP;
    chk(8'(irq_req), 8'h00);
    put(3, 8'h01);
    chk(8'(irq_req), 8'h01);
    put(5, 8'h01);
    chk(8'(timer_flag_reg), 8'h00);
    // Compare A flag lands one tick after the match
    put(1, 8'h20);
    chk(compare_value_a, 8'h20);
    put(0, 8'h1e);
    clock_source_select = CS_DIV1;
    while (timer_flag_reg[FLAG_CMA] !== 1'b1) step(1);
    chk(counter_value, 8'h22);
    clock_source_select = CS_STOP;
    put(4, 8'h02);
    chk(8'(timer_flag_reg), 8'h00);
    // Writing the match value suppresses that match
    put(2, 8'h40);
    chk(compare_value_b, 8'h40);
    put(0, 8'h40);
    clock_source_select = CS_DIV1;
    step(10);
    clock_source_select = CS_STOP;
    chk(8'(timer_flag_reg), 8'h00);
    put(0, 8'h3f);
    clock_source_select = CS_DIV1;
    step(6);
    clock_source_select = CS_STOP;
    chk(8'(timer_flag_reg), 8'h04);
    put(4, 8'h04);
    // External pin, falling then rising edges
    for (int s = 6; s <= 7; s++) begin
      put(0, 8'h00);
      clock_source_select = 3'(s);
      pin_u.pulses(5);
      step(3);
      chk(counter_value, 8'h05);
      clock_source_select = CS_STOP;
    end
    // Phase-correct turns round at the top
    put(0, 8'hfd);
    {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0} = WGM_PC_MAX;
    clock_source_select = CS_DIV1;
    while (counter_value !== 8'h80) step(1);
    chk(8'(count_down), 8'h01);
    step(1);
    chk(counter_value, 8'h7f);
    // Clear on compare A as top
    clock_source_select = CS_STOP;
    {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0} = WGM_CTC;
    put(0, 8'h00);
    clock_source_select = CS_DIV1;
    while (counter_value !== 8'h20) step(1);
    chk(8'(at_top), 8'h01);
    step(1);
    chk(counter_value, 8'h00);
    conclude();
  end
endmodule : tb_top
